// *** enc_model.sv ***
// quadrature encoder and parallel stop position source
// assumes one edge per clock while stepping
`timescale 1ns/1ps
module enc_model (
  input  wire        clk,     // clock
  input  wire        srst,    // reset, high
  input  wire        stepReq, // one edge per cycle
  input  wire        stepDir, // 1 counts up
  input  wire [15:0] posCmd,  // stop position
  output reg         encA,    // phase a
  output reg         encB,    // phase b
  output wire [15:0] extData  // parallel lines
);
  reg  [1:0] phReg;
  wire [1:0] phNext = stepDir ? phReg + 2'h1 : phReg - 2'h1;
  assign extData = posCmd;
  always @(posedge clk)
  begin
    if (srst)
      phReg <= 2'h0;
    else if (stepReq)
      phReg <= phNext;
  end
  // gray sequence, b leads for up
  always @*
  begin
    encA = phReg[1];
    encB = phReg[1] ^ phReg[0];
  end
endmodule

// *** orient_chk_sva.sv ***
// port checker for the orientation stop select block
// assumes binding onto the top module, one clock, sync reset
`timescale 1ns/1ps
module orient_chk #(
  parameter STILL_CYC = 8,  // stop detect cycles
  parameter CHK_CYC   = 16  // fault wait cycles
) (
  input wire        clk,                // clock
  input wire        srst,               // reset
  input wire        awvalid,            // aw valid
  input wire        awready,            // aw ready
  input wire        wvalid,             // w valid
  input wire        wready,             // w ready
  input wire [1:0]  bresp,              // b resp
  input wire        bvalid,             // b valid
  input wire        bready,             // b ready
  input wire        arvalid,            // ar valid
  input wire        arready,            // ar ready
  input wire [31:0] rdata,              // r data
  input wire        rvalid,             // r valid
  input wire        rready,             // r ready
  input wire        startIn,            // start
  input wire        switchSpeedReached, // switchover speed
  input wire [2:0]  speedStage,         // stage
  input wire        irq                 // interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  chk_write_resp: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response missing");
  chk_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  chk_write_busy: assert property (bvalid |-> !awready && !wready)
    else $error("write accepted while busy");
  chk_read_resp: assert property (arvalid && arready |=> rvalid)
    else $error("read data missing");
  chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  chk_read_busy: assert property (rvalid |-> !arready)
    else $error("read accepted while busy");
  chk_start_gate: assert property (speedStage == 3'h0 ##1 speedStage == 3'h1
    |-> $past(startIn, 2)) else $error("decel without start");
  chk_switch_gate: assert property (speedStage == 3'h1 ##1 speedStage == 3'h2
    |-> $past(switchSpeedReached, 2)) else $error("calc before switchover speed");
  chk_lock_order: assert property (speedStage != 3'h3 ##1 speedStage == 3'h3
    |-> $past(speedStage) == 3'h2) else $error("lock not from creep");
  chk_lock_exit: assert property (speedStage == 3'h3 |=> speedStage == 3'h3 || speedStage == 3'h0)
    else $error("lock left to a moving stage");
  cover property (speedStage == 3'h3);
  cover property (irq);
  cover property (bvalid && bresp == 2'h2);
endmodule

bind spindle_orientation_stop_select orient_chk #(
  .STILL_CYC(STILL_CYC),
  .CHK_CYC  (CHK_CYC)
) chkI (
  .clk(clk), .srst(srst), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .rready(rready),
  .startIn(startIn), .switchSpeedReached(switchSpeedReached), .speedStage(speedStage),
  .irq(irq)
);

// *** orient_defs.vh ***
// constants for the spindle orientation stop select block
// assumes a 40 MHz clock and an 8-bit AXI4-Lite byte address
`ifndef ORIENT_DEFS_VH
`define ORIENT_DEFS_VH
`define A_SRC     8'h00
`define A_ISTOP   8'h04
`define A_XSEL    8'h08
`define A_PPR     8'h0c
`define A_MONSEL  8'h10
`define A_ZONE    8'h14
`define A_INF0    8'h18
`define A_INF1    8'h1c
`define A_INF2    8'h20
`define A_OUTF0   8'h24
`define A_OUTF1   8'h28
`define A_OPTCFG  8'h2c
`define A_STAT    8'h30
`define A_MONV    8'h34
`define A_IST     8'h38
`define A_ICLR    8'h3c
`define A_IEN     8'h40
`define RST_SRC   16'h270f
`define RST_PPR   13'h0400
`define RST_ZONE  12'h005
`define SRC_INT   16'h0000
`define SRC_EXT   16'h0001
`define XSEL_SPD  8'h00
`define XSEL_DIR  8'h01
`define XSEL_MAX  8'h7f
`define FN_ORIENT 8'h16
`define FN_DONE   8'h1b
`define FN_DONEN  8'h7f
`define FN_FAULT  8'h1c
`define FN_FAULTN 8'h80
`define MON_PULSE 8'h13
`define CLK_MHZ   40
`define STILL_US  1000
`define STILL_CYC (`STILL_US * `CLK_MHZ)
`define CHK_MS    500
`define CHK_CYC   (`CHK_MS * 1000 * `CLK_MHZ)
`define IEV_START 0
`define IEV_DONE  1
`define IEV_FAULT 2
`define RESP_OK   2'h0
`define RESP_ERR  2'h2
`endif

// *** spindle_orientation_stop_select.v ***
// orientation control: stop address select, encoder count, orient sequence
// assumes all pins synchronous to clk; registers over AXI4-Lite
`timescale 1ns/1ps
`include "orient_defs.vh"
module spindle_orientation_stop_select #(
  parameter STILL_CYC = `STILL_CYC, // no-edge cycles meaning stopped
  parameter CHK_CYC   = `CHK_CYC    // stopped outside zone before fault
) (
  input  wire        clk,                // 40 MHz clock
  input  wire        srst,               // sync reset, high
  input  wire [7:0]  awaddr,             // write address
  input  wire        awvalid,            // write address valid
  output reg         awready,            // write address ready
  input  wire [31:0] wdata,              // write data
  input  wire [3:0]  wstrb,              // write byte strobes
  input  wire        wvalid,             // write data valid
  output reg         wready,             // write data ready
  output reg  [1:0]  bresp,              // write response
  output reg         bvalid,             // write response valid
  input  wire        bready,             // write response ready
  input  wire [7:0]  araddr,             // read address
  input  wire        arvalid,            // read address valid
  output reg         arready,            // read address ready
  output reg  [31:0] rdata,              // read data
  output reg  [1:0]  rresp,              // read response
  output reg         rvalid,             // read data valid
  input  wire        rready,             // read data ready
  input  wire [11:0] inTerm,             // contact input terminals
  input  wire        startIn,            // start signal
  input  wire        encA,               // encoder phase a
  input  wire        encB,               // encoder phase b
  input  wire        optionPresent,      // 16-bit input board fitted
  input  wire        vectorMode,         // vector control active
  input  wire [15:0] extData,            // 16-bit parallel input
  input  wire        dataReadStrobe,     // external data read timing
  input  wire        switchSpeedReached, // speed at switchover speed
  output reg  [6:0]  outTerm,            // output terminals
  output reg  [2:0]  speedStage,         // 0 run 1 decel 2 creep 3 lock
  output reg  [15:0] stopAddr,           // selected stop address
  output reg  [15:0] speedCmd,           // speed or torque command
  output reg  [15:0] monitorOut,         // display data
  output reg         irq                 // level interrupt
);
  localparam [4:0] ST_IDLE  = 5'h01;
  localparam [4:0] ST_DECEL = 5'h02;
  localparam [4:0] ST_CALC  = 5'h04;
  localparam [4:0] ST_CREEP = 5'h08;
  localparam [4:0] ST_LOCK  = 5'h10;

  reg [15:0] srcSel_reg;
  reg [13:0] intStop_reg;
  reg [7:0]  extSel_reg;
  reg [12:0] ppr_reg;
  reg [7:0]  monSel_reg;
  reg [11:0] zone_reg;
  reg [31:0] inf0_reg;
  reg [31:0] inf1_reg;
  reg [31:0] inf2_reg;
  reg [31:0] outf0_reg;
  reg [31:0] outf1_reg;
  reg        optCfg_reg;
  reg [2:0]  ist_reg;
  reg [2:0]  ien_reg;
  reg [7:0]  awAddr_reg;
  reg        awHave_reg;
  reg [31:0] wData_reg;
  reg [3:0]  wStrb_reg;
  reg        wHave_reg;
  reg [4:0]  state_reg;
  reg [4:0]  state_next;
  reg [15:0] pos_reg;
  reg [15:0] raw_reg;
  reg        prevA_reg;
  reg        prevB_reg;
  reg [31:0] still_reg;
  reg [31:0] chk_reg;
  reg [15:0] extLatch_reg;
  reg [15:0] dist_reg;
  reg [15:0] stopDist_reg;
  reg        done_reg;
  reg        fault_reg;
  reg        doneOut_reg;
  reg        faultOut_reg;
  reg [15:0] target_next;
  reg [31:0] rd_next;
  reg [1:0]  rresp_next;
  reg        orientCmd;
  reg [6:0]  outTerm_next;
  integer    i;
  integer    j;

  // merge byte lanes of a write
  function [31:0] applyStrb;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer k;
    begin
      applyStrb = old;
      for (k = 0; k < 4; k = k + 1)
        if (strb[k])
          applyStrb[k*8 +: 8] = nw[k*8 +: 8];
    end
  endfunction

  // limit a value to the top address
  function [15:0] satTop;
    input [15:0] v;
    input [15:0] top;
    begin
      satTop = (v > top) ? top : v;
    end
  endfunction

  // drive one output terminal from its function code
  function routeOut;
    input [7:0] code;
    input       done;
    input       fault;
    begin
      if (code == `FN_DONE)
        routeOut = done;
      else if (code == `FN_DONEN)
        routeOut = ~done;
      else if (code == `FN_FAULT)
        routeOut = fault;
      else if (code == `FN_FAULTN)
        routeOut = ~fault;
      else
        routeOut = 1'b0;
    end
  endfunction

  wire [95:0] infAll   = {inf2_reg, inf1_reg, inf0_reg};
  wire [63:0] outfAll  = {outf1_reg, outf0_reg};
  wire [15:0] modulus  = {1'b0, ppr_reg, 2'b00};
  wire [15:0] topAddr  = (modulus == 16'h0000) ? 16'h0000 : modulus - 16'h0001;
  wire        qEdge    = (encA ^ prevA_reg) ^ (encB ^ prevB_reg);
  wire        qUp      = prevA_reg ^ encB;
  wire        stopped  = (still_reg == STILL_CYC);
  // only sources 0 and 1 enable orientation
  wire        orientEn = (srcSel_reg == `SRC_INT) || (srcSel_reg == `SRC_EXT);
  wire        orientOn = orientCmd && orientEn;
  wire        useExt   = (srcSel_reg == `SRC_EXT) && optionPresent &&
                         (extSel_reg != `XSEL_SPD) && (extSel_reg <= `XSEL_MAX);
  wire [15:0] distRev  = modulus - dist_reg;
  wire        inZone   = ({4'h0, zone_reg} >= dist_reg) || ({4'h0, zone_reg} >= distRev);
  wire [15:0] posSum   = target_next + modulus - pos_reg;
  wire [15:0] distNow  = (posSum >= modulus) ? posSum - modulus : posSum;
  wire [6:0]  divCmd   = (extLatch_reg > {8'h00, extSel_reg}) ?
                         extSel_reg[6:0] : extLatch_reg[6:0];
  wire [22:0] divProd  = divCmd * modulus;
  wire [22:0] divQuot  = divProd / ({15'h0000, extSel_reg} + 23'h000001);
  wire        startEv  = (state_reg == ST_IDLE) && orientOn && startIn;

  // orient command from any terminal coded 22
  always @*
  begin
    orientCmd = 1'b0;
    for (i = 0; i < 12; i = i + 1)
      if (inTerm[i] && (infAll[i*8 +: 8] == `FN_ORIENT))
        orientCmd = 1'b1;
  end

  always @*
  begin
    outTerm_next = 7'h00;
    for (j = 0; j < 7; j = j + 1)
      outTerm_next[j] = routeOut(outfAll[j*8 +: 8], doneOut_reg, faultOut_reg);
  end

  // stop address from the selected source
  always @*
  begin
    target_next = satTop({2'b00, intStop_reg}, topAddr);
    if (useExt)
    begin
      if (extSel_reg == `XSEL_DIR)
        target_next = satTop(extLatch_reg, topAddr);
      else
        target_next = divQuot[15:0];
    end
  end

  // orientation sequence
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (startEv)
          state_next = ST_DECEL;
      ST_DECEL:
        if (switchSpeedReached)
          state_next = ST_CALC;
      ST_CALC:
        state_next = ST_CREEP;
      ST_CREEP:
        if (inZone)
          state_next = ST_LOCK;
      ST_LOCK:
        state_next = ST_LOCK;
      default:
        state_next = ST_IDLE;
    endcase
    if (!orientOn)
      state_next = ST_IDLE;
  end

  always @(posedge clk)
  begin
    if (srst)
    begin
      state_reg    <= ST_IDLE;
      pos_reg      <= 16'h0000;
      raw_reg      <= 16'h0000;
      prevA_reg    <= 1'b0;
      prevB_reg    <= 1'b0;
      still_reg    <= 32'h00000000;
      chk_reg      <= 32'h00000000;
      extLatch_reg <= 16'h0000;
      dist_reg     <= 16'h0000;
      stopDist_reg <= 16'h0000;
      done_reg     <= 1'b0;
      fault_reg    <= 1'b0;
      doneOut_reg  <= 1'b0;
      faultOut_reg <= 1'b0;
      outTerm      <= 7'h00;
      speedStage   <= 3'h0;
      stopAddr     <= 16'h0000;
      speedCmd     <= 16'h0000;
      monitorOut   <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      prevA_reg <= encA;
      prevB_reg <= encB;
      if (qEdge)
      begin
        raw_reg <= qUp ? raw_reg + 16'h0001 : raw_reg - 16'h0001;
        if (qUp)
          pos_reg <= (pos_reg >= topAddr) ? 16'h0000 : pos_reg + 16'h0001;
        else
          pos_reg <= (pos_reg == 16'h0000 || pos_reg > topAddr) ? topAddr :
                     pos_reg - 16'h0001;
      end
      if (qEdge)
        still_reg <= 32'h00000000;
      else if (!stopped)
        still_reg <= still_reg + 32'h00000001;
      // capture point depends on control mode
      if (vectorMode ? startEv : dataReadStrobe)
        extLatch_reg <= extData;
      stopAddr <= target_next;
      dist_reg <= distNow;
      if (state_reg == ST_CALC)
        stopDist_reg <= dist_reg;
      if ((state_reg == ST_CREEP || state_reg == ST_LOCK) && stopped && !inZone)
        chk_reg <= (chk_reg == CHK_CYC) ? chk_reg : chk_reg + 32'h00000001;
      else
        chk_reg <= 32'h00000000;
      // stopped in zone under servo lock
      done_reg  <= (state_reg == ST_LOCK) && inZone && stopped;
      fault_reg <= (chk_reg == CHK_CYC);
      doneOut_reg  <= done_reg && orientOn && startIn;
      faultOut_reg <= fault_reg && orientOn && startIn;
      outTerm <= outTerm_next;
      if (state_reg == ST_DECEL)
        speedStage <= 3'h1;
      else if (state_reg == ST_CALC || state_reg == ST_CREEP)
        speedStage <= 3'h2;
      else if (state_reg == ST_LOCK)
        speedStage <= 3'h3;
      else
        speedStage <= 3'h0;
      if (extSel_reg == `XSEL_SPD)
        speedCmd <= extData ^ {16{optCfg_reg}};
      else
        speedCmd <= 16'h0000;
      monitorOut <= (monSel_reg == `MON_PULSE) ? raw_reg : stopAddr;
    end
  end

  // register read mux
  always @*
  begin
    rd_next    = 32'h00000000;
    rresp_next = `RESP_OK;
    if (araddr == `A_SRC)
      rd_next = {16'h0000, srcSel_reg};
    else if (araddr == `A_ISTOP)
      rd_next = {18'h00000, intStop_reg};
    else if (araddr == `A_XSEL)
      rd_next = {24'h000000, extSel_reg};
    else if (araddr == `A_PPR)
      rd_next = {19'h00000, ppr_reg};
    else if (araddr == `A_MONSEL)
      rd_next = {24'h000000, monSel_reg};
    else if (araddr == `A_ZONE)
      rd_next = {20'h00000, zone_reg};
    else if (araddr == `A_INF0)
      rd_next = inf0_reg;
    else if (araddr == `A_INF1)
      rd_next = inf1_reg;
    else if (araddr == `A_INF2)
      rd_next = inf2_reg;
    else if (araddr == `A_OUTF0)
      rd_next = outf0_reg;
    else if (araddr == `A_OUTF1)
      rd_next = {8'h00, outf1_reg[23:0]};
    else if (araddr == `A_OPTCFG)
      rd_next = {31'h00000000, optCfg_reg};
    else if (araddr == `A_STAT)
      rd_next = {pos_reg, 3'h0, state_reg, 3'h0, faultOut_reg, doneOut_reg,
                 speedStage};
    else if (araddr == `A_MONV)
      rd_next = {stopDist_reg, monitorOut};
    else if (araddr == `A_IST)
      rd_next = {29'h00000000, ist_reg};
    else if (araddr == `A_ICLR)
      rd_next = 32'h00000000;
    else if (araddr == `A_IEN)
      rd_next = {29'h00000000, ien_reg};
    else
      rresp_next = `RESP_ERR;
  end

  wire        doWrite = awHave_reg && wHave_reg && !bvalid;
  wire [31:0] wMerged = applyStrb(32'h00000000, wData_reg, wStrb_reg);
  wire [31:0] mSrc    = applyStrb({16'h0000, srcSel_reg}, wData_reg, wStrb_reg);
  wire [31:0] mIstop  = applyStrb({18'h0, intStop_reg}, wData_reg, wStrb_reg);
  wire [31:0] mXsel   = applyStrb({24'h0, extSel_reg}, wData_reg, wStrb_reg);
  wire [31:0] mPpr    = applyStrb({19'h0, ppr_reg}, wData_reg, wStrb_reg);
  wire [31:0] mMonSel = applyStrb({24'h0, monSel_reg}, wData_reg, wStrb_reg);
  wire [31:0] mZone   = applyStrb({20'h0, zone_reg}, wData_reg, wStrb_reg);
  wire [31:0] mIen    = applyStrb({29'h0, ien_reg}, wData_reg, wStrb_reg);
  wire [2:0]  events  = {fault_reg & ~faultOut_reg & orientOn & startIn,
                         done_reg & ~doneOut_reg & orientOn & startIn,
                         startEv};

  // AXI4-Lite slave and register file
  always @(posedge clk)
  begin
    if (srst)
    begin
      awready     <= 1'b1;
      wready      <= 1'b1;
      bvalid      <= 1'b0;
      bresp       <= `RESP_OK;
      arready     <= 1'b1;
      rvalid      <= 1'b0;
      rdata       <= 32'h00000000;
      rresp       <= `RESP_OK;
      awAddr_reg  <= 8'h00;
      awHave_reg  <= 1'b0;
      wData_reg   <= 32'h00000000;
      wStrb_reg   <= 4'h0;
      wHave_reg   <= 1'b0;
      srcSel_reg  <= `RST_SRC;
      intStop_reg <= 14'h0000;
      extSel_reg  <= `XSEL_SPD;
      ppr_reg     <= `RST_PPR;
      monSel_reg  <= 8'h00;
      zone_reg    <= `RST_ZONE;
      inf0_reg    <= 32'h00000000;
      inf1_reg    <= 32'h00000000;
      inf2_reg    <= 32'h00000000;
      outf0_reg   <= 32'h00000000;
      outf1_reg   <= 32'h00000000;
      optCfg_reg  <= 1'b0;
      ist_reg     <= 3'h0;
      ien_reg     <= 3'h0;
      irq         <= 1'b0;
    end
    else
    begin
      if (awvalid && awready)
      begin
        awAddr_reg <= awaddr;
        awHave_reg <= 1'b1;
        awready    <= 1'b0;
      end
      if (wvalid && wready)
      begin
        wData_reg <= wdata;
        wStrb_reg <= wstrb;
        wHave_reg <= 1'b1;
        wready    <= 1'b0;
      end
      // sticky events, set beats clear
      ist_reg <= ist_reg | events;
      if (doWrite)
      begin
        awHave_reg <= 1'b0;
        wHave_reg  <= 1'b0;
        bvalid     <= 1'b1;
        bresp      <= `RESP_OK;
        if (awAddr_reg == `A_SRC)
          srcSel_reg <= mSrc[15:0];
        else if (awAddr_reg == `A_ISTOP)
          intStop_reg <= mIstop[13:0];
        else if (awAddr_reg == `A_XSEL)
          extSel_reg <= mXsel[7:0];
        else if (awAddr_reg == `A_PPR)
          ppr_reg <= mPpr[12:0];
        else if (awAddr_reg == `A_MONSEL)
          monSel_reg <= mMonSel[7:0];
        else if (awAddr_reg == `A_ZONE)
          zone_reg <= mZone[11:0];
        else if (awAddr_reg == `A_INF0)
          inf0_reg <= applyStrb(inf0_reg, wData_reg, wStrb_reg);
        else if (awAddr_reg == `A_INF1)
          inf1_reg <= applyStrb(inf1_reg, wData_reg, wStrb_reg);
        else if (awAddr_reg == `A_INF2)
          inf2_reg <= applyStrb(inf2_reg, wData_reg, wStrb_reg);
        else if (awAddr_reg == `A_OUTF0)
          outf0_reg <= applyStrb(outf0_reg, wData_reg, wStrb_reg);
        else if (awAddr_reg == `A_OUTF1)
          outf1_reg <= applyStrb(outf1_reg, wData_reg, wStrb_reg) & 32'h00ffffff;
        else if (awAddr_reg == `A_OPTCFG)
          optCfg_reg <= wStrb_reg[0] ? wData_reg[0] : optCfg_reg;
        else if (awAddr_reg == `A_ICLR)
          ist_reg <= (ist_reg & ~wMerged[2:0]) | events;
        else if (awAddr_reg == `A_IEN)
          ien_reg <= mIen[2:0];
        else if (awAddr_reg != `A_STAT && awAddr_reg != `A_MONV &&
                 awAddr_reg != `A_IST)
          bresp <= `RESP_ERR;
      end
      if (bvalid && bready)
      begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
      if (arvalid && arready)
      begin
        rdata   <= rd_next;
        rresp   <= rresp_next;
        rvalid  <= 1'b1;
        arready <= 1'b0;
      end
      if (rvalid && rready)
      begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
      irq <= |(ist_reg & ien_reg);
    end
  end
endmodule

// *** tb.sv ***
// self-checking bench for the orientation stop select block
// assumes orient_defs.vh, enc_model and the bound checker
`timescale 1ns/1ps
`include "orient_defs.vh"
module tb;
  reg         clk, srst, awvalid, wvalid, bready, arvalid, rready;
  reg  [7:0]  awaddr, araddr;
  reg  [31:0] wdata, rd;
  reg  [3:0]  wstrb;
  reg  [11:0] inTerm;
  reg         startIn, optionPresent, vectorMode, dataReadStrobe, switchSpeedReached;
  reg         stepReq, stepDir;
  reg  [15:0] posCmd;
  wire        awready, wready, bvalid, arready, rvalid, encA, encB, irq;
  wire [1:0]  bresp, rresp;
  wire [31:0] rdata;
  wire [15:0] extData, stopAddr, speedCmd, monitorOut;
  wire [6:0]  outTerm;
  wire [2:0]  speedStage;
  integer     error_cnt = 0, total_checks = 0, cyc = 0;
  spindle_orientation_stop_select #(.STILL_CYC(8), .CHK_CYC(16)) uut (
    .clk(clk), .srst(srst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .inTerm(inTerm), .startIn(startIn), .encA(encA), .encB(encB),
    .optionPresent(optionPresent), .vectorMode(vectorMode), .extData(extData),
    .dataReadStrobe(dataReadStrobe), .switchSpeedReached(switchSpeedReached),
    .outTerm(outTerm), .speedStage(speedStage), .stopAddr(stopAddr),
    .speedCmd(speedCmd), .monitorOut(monitorOut), .irq(irq));
  enc_model encI (.clk(clk), .srst(srst), .stepReq(stepReq), .stepDir(stepDir),
    .posCmd(posCmd), .encA(encA), .encB(encB), .extData(extData));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task complete_run;
    begin
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      error_cnt = error_cnt + 1;
      complete_run;
    end
  end
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp)
      begin
        error_cnt = error_cnt + 1;
        $display("[ERR] %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task axw(input [7:0] a, input [31:0] d, input [1:0] er);
    begin
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      do
      begin
        @(posedge clk);
        if (awready)
          awvalid <= 1'b0;
        if (wready)
          wvalid <= 1'b0;
      end
      while (!bvalid);
      bready <= 1'b0;
      chk("bresp", 32'(bresp), 32'(er));
      @(posedge clk);
    end
  endtask
  task axr(input [7:0] a, input [1:0] er);
    begin
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do
      begin
        @(posedge clk);
        if (arready)
          arvalid <= 1'b0;
      end
      while (!rvalid);
      rd = rdata;
      rready <= 1'b0;
      chk("rresp", 32'(rresp), 32'(er));
      @(posedge clk);
    end
  endtask
  task waitHi(input integer b);
    integer n;
    begin
      n = 0;
      while (outTerm[b] !== 1'b1 && n < 300)
      begin
        @(posedge clk);
        n = n + 1;
      end
    end
  endtask
  task selChk(input [7:0] x, input [15:0] c, input [15:0] e);
    begin
      axw(`A_XSEL, 32'(x), `RESP_OK);
      posCmd <= c;
      dataReadStrobe <= 1'b1;
      wt(1);
      dataReadStrobe <= 1'b0;
      wt(4);
      chk("stop addr", 32'(stopAddr), 32'(e));
    end
  endtask
  initial
  begin
    srst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, stepReq, stepDir} = 7'h0;
    {awaddr, araddr, wdata, posCmd, inTerm} = 76'h0;
    wstrb = 4'hf;
    {startIn, optionPresent, vectorMode, dataReadStrobe, switchSpeedReached} = 5'h0;
    wt(20);
    srst <= 1'b0;
    wt(1);
    axr(`A_SRC, `RESP_OK);
    chk("source", rd, 32'h270f);
    axr(`A_PPR, `RESP_OK);
    chk("pulses", rd, 32'h400);
    axr(8'h44, `RESP_ERR);
    chk("unmapped", rd, 32'h0);
    axw(8'h48, 32'h1, `RESP_ERR);
    axw(`A_PPR, 32'h4, `RESP_OK);
    axw(`A_INF0, {`FN_ORIENT, 24'h0}, `RESP_OK);
    axw(`A_OUTF0, {`FN_FAULTN, `FN_FAULT, `FN_DONEN, `FN_DONE}, `RESP_OK);
    axw(`A_IEN, 32'h7, `RESP_OK);
    inTerm <= 12'h008;
    startIn <= 1'b1;
    wt(6);
    chk("idle outputs", 32'(outTerm[3:0]), 32'ha);
    chk("disabled", 32'(speedStage), 32'h0);
    inTerm <= 12'h020;
    axw(`A_ISTOP, 32'h2, `RESP_OK);
    axw(`A_SRC, 32'(`SRC_INT), `RESP_OK);
    wt(6);
    chk("wrong input", 32'(speedStage), 32'h0);
    inTerm <= 12'h008;
    wt(4);
    chk("decel", 32'(speedStage), 32'h1);
    chk("irq start", 32'(irq), 32'h1);
    switchSpeedReached <= 1'b1;
    waitHi(0);
    chk("done outputs", 32'(outTerm[3:0]), 32'h9);
    chk("lock", 32'(speedStage), 32'h3);
    axr(`A_IST, `RESP_OK);
    chk("irq status", rd, 32'h3);
    axw(`A_ICLR, 32'h3, `RESP_OK);
    axr(`A_IST, `RESP_OK);
    chk("cleared", rd, 32'h0);
    chk("irq low", 32'(irq), 32'h0);
    inTerm <= 12'h000;
    wt(5);
    chk("cmd off", 32'(outTerm[3:0]), 32'ha);
    chk("cmd off stage", 32'(speedStage), 32'h0);
    axw(`A_ISTOP, 32'h8, `RESP_OK);
    axw(`A_IEN, 32'h0, `RESP_OK);
    inTerm <= 12'h008;
    waitHi(2);
    chk("fault outputs", 32'(outTerm[3:0]), 32'h6);
    chk("masked irq", 32'(irq), 32'h0);
    axr(`A_IST, `RESP_OK);
    chk("fault status", rd, 32'h5);
    startIn <= 1'b0;
    wt(5);
    chk("start off", 32'(outTerm[3:0]), 32'ha);
    inTerm <= 12'h000;
    axw(`A_MONSEL, 32'(`MON_PULSE), `RESP_OK);
    stepDir <= 1'b1;
    stepReq <= 1'b1;
    wt(20);
    stepReq <= 1'b0;
    wt(3);
    chk("raw up", 32'(monitorOut), 32'd20);
    axr(`A_STAT, `RESP_OK);
    chk("pos wrap", rd >> 16, 32'd4);
    stepDir <= 1'b0;
    stepReq <= 1'b1;
    wt(5);
    stepReq <= 1'b0;
    wt(3);
    chk("raw down", 32'(monitorOut), 32'd15);
    axr(`A_STAT, `RESP_OK);
    chk("pos under", rd >> 16, 32'd15);
    axw(`A_MONSEL, 32'h0, `RESP_OK);
    wt(3);
    chk("monitor addr", 32'(monitorOut), 32'd8);
    axw(`A_PPR, 32'h400, `RESP_OK);
    axw(`A_OPTCFG, 32'h1, `RESP_OK);
    axw(`A_SRC, 32'(`SRC_EXT), `RESP_OK);
    optionPresent <= 1'b1;
    selChk(8'd1, 16'h0800, 16'h0800);
    selChk(8'd1, 16'd5000, 16'd4095);
    selChk(8'd89, 16'd10, 16'd455);
    selChk(8'd89, 16'd200, 16'd4050);
    chk("speed off", 32'(speedCmd), 32'h0);
    selChk(8'd0, 16'd300, 16'd8);
    chk("speed inv", 32'(speedCmd), 32'hfed3);
    axw(`A_OPTCFG, 32'h0, `RESP_OK);
    wt(3);
    chk("speed cmd", 32'(speedCmd), 32'd300);
    optionPresent <= 1'b0;
    selChk(8'd1, 16'd200, 16'd8);
    optionPresent <= 1'b1;
    selChk(8'd1, 16'd200, 16'd200);
    vectorMode <= 1'b1;
    selChk(8'd1, 16'd300, 16'd200);
    startIn <= 1'b1;
    inTerm <= 12'h008;
    wt(4);
    chk("capture", 32'(stopAddr), 32'd300);
    complete_run;
  end
endmodule
